// ### hw/modulator_consts.svh
// constants for the modulator carrier selection block
`ifndef MODULATOR_CONSTS_SVH
`define MODULATOR_CONSTS_SVH

// ========================================
// register map (byte addresses)
`define ADDR_BITS 12
`define HI_CTRL_OFS 12'h000
`define LO_CTRL_OFS 12'h004
`define MOD_CTRL_OFS 12'h008
`define SRC_CTRL_OFS 12'h00c

// ========================================
// writable bits and reset values
`define CAR_WMASK 8'hef
`define MOD_WMASK 8'hf1
`define SRC_WMASK 8'h8f
`define CAR_RESET 8'h00
`define MOD_RESET 8'h20
`define SRC_RESET 8'h00

// ========================================
// carrier control fields
`define CAR_PIN_DIS_BIT 7
`define CAR_INV_BIT 6
`define CAR_SYNC_BIT 5
`define CAR_SEL_MSB 3
`define CAR_SEL_W 4
`define CAR_RSVD_BIT 4

// ========================================
// modulation control fields
`define MOD_EN_BIT 7
`define MOD_OE_BIT 6
`define MOD_SLR_BIT 5
`define MOD_OPOL_BIT 4
`define MOD_STAT_BIT 3

// ========================================
// bus encodings
`define HTRANS_ACTIVE_BIT 1
`define HRESP_OKAY 1'h0
`define RDATA_PAD 24'h000000

`endif

// ### hw/modulator_pkg.sv
// types shared by the modulator carrier selection block
package modulator_pkg;

	// which carrier path currently feeds the mixer
	typedef enum logic {PATH_LOW, PATH_HIGH} path_e;

	// state of one carrier conditioning path
	typedef struct packed {
		logic prev;
	} carrier_path_s;

	// state of the top block
	typedef struct packed {
		logic [7:0] hi_ctrl;
		logic [7:0] lo_ctrl;
		logic [7:0] mod_ctrl;
		logic [7:0] src_ctrl;
		logic wr_pend;
		logic [11:0] wr_addr;
		logic [31:0] rdata;
		logic ready;
		logic resp;
		path_e path;
		logic status;
		logic out;
		logic [7:0] pin_dis;
	} modulator_s;

endpackage

// ### hw/carrier_path.sv
// one carrier path: source pick, inversion and falling edge detect
`timescale 1ns/1ps
`include "modulator_consts.svh"

module carrier_path
	import modulator_pkg::*;
#(
	parameter int SEL_W = `CAR_SEL_W,
	parameter int NSRC = 2 ** (SEL_W - 1)
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [SEL_W-1:0] select,
	input wire logic invert,
	input wire logic [NSRC-1:0] sources,
	output logic carrier,
	output logic fall
);

	carrier_path_s st_reg;
	carrier_path_s st_next;
	logic picked;

	// ========================================
	// source pick and conditioning
	// reserved codes (top bit set) connect nothing
	always_comb begin
		picked = 1'b0;
		if (!select[SEL_W-1]) begin // [R3]
			picked = sources[select[SEL_W-2:0]];
		end
		carrier = picked ^ invert;
		// edge seen on the conditioned carrier, after inversion
		fall = st_reg.prev & ~carrier; // [R15]
		st_next.prev = carrier;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	a_reserved_quiet: assert property ( // [R3]
		@(posedge hclk) disable iff (!hresetn)
		select[SEL_W-1] |-> (carrier == invert))
		else $error("reserved code connected a source");

	a_fall_conditioned: assert property ( // [R15]
		@(posedge hclk) disable iff (!hresetn)
		fall |-> ($past(carrier) && !carrier))
		else $error("falling edge not on conditioned carrier");

endmodule // carrier_path

// ### hw/modulator_carrier_select.sv
// carrier selection, synchronisation and mixing with an AHB-Lite slave
`timescale 1ns/1ps
`include "modulator_consts.svh"

// Behaviour
// R1: high selector codes 0..7 pick sources
// R2: low selector uses same source encoding
// R3: codes 8..15 connect no source
// R4: high invert bit inverts high carrier
// R5: low invert bit inverts low carrier
// R6: high sync waits high falling edge
// R7: low sync waits low falling edge
// R8: no sync means switch immediately
// R9: high pin disable gates source pin
// R10: low pin disable gates source pin
// R11: bit four reads zero, ignores writes
// R12: high carrier when modulator high, else low
// R13: no output while module disabled
// R14: pin output off holds pin low
// R15: inversion applies before edge detection
module modulator_carrier_select
	import modulator_pkg::*;
#(
	parameter int SEL_W = `CAR_SEL_W,
	parameter int NSRC = 2 ** (SEL_W - 1),
	parameter int NPWM = 4
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic modulator_in,
	input wire logic ext_carrier_pin_a,
	input wire logic ext_carrier_pin_b,
	input wire logic ref_clock_in,
	input wire logic [NPWM-1:0] capture_pwm_unit_in,
	output logic modulated_output,
	output logic modulated_slew_limit,
	output logic [NSRC-1:0] source_pin_disable
);

	localparam int IDX_W = SEL_W - 1;

	modulator_s st_reg;
	modulator_s st_next;
	logic [NSRC-1:0] sources;
	logic hi_carrier;
	logic hi_fall;
	logic lo_carrier;
	logic lo_fall;
	logic accept;
	logic mixed;
	logic [NSRC-1:0] pin_dis_w;

	// ========================================
	// control field views
	logic [SEL_W-1:0] hi_sel;
	logic [SEL_W-1:0] lo_sel;
	logic hi_inv;
	logic lo_inv;
	logic hi_sync;
	logic lo_sync;
	logic hi_pdis;
	logic lo_pdis;
	logic mod_en;
	logic mod_oe;
	logic mod_opol;

	assign hi_sel = st_reg.hi_ctrl[`CAR_SEL_MSB:0];
	assign lo_sel = st_reg.lo_ctrl[`CAR_SEL_MSB:0];
	assign hi_inv = st_reg.hi_ctrl[`CAR_INV_BIT];
	assign lo_inv = st_reg.lo_ctrl[`CAR_INV_BIT];
	assign hi_sync = st_reg.hi_ctrl[`CAR_SYNC_BIT];
	assign lo_sync = st_reg.lo_ctrl[`CAR_SYNC_BIT];
	assign hi_pdis = st_reg.hi_ctrl[`CAR_PIN_DIS_BIT];
	assign lo_pdis = st_reg.lo_ctrl[`CAR_PIN_DIS_BIT];
	assign mod_en = st_reg.mod_ctrl[`MOD_EN_BIT];
	assign mod_oe = st_reg.mod_ctrl[`MOD_OE_BIT];
	assign mod_opol = st_reg.mod_ctrl[`MOD_OPOL_BIT];

	// ========================================
	// source vector in selector code order
	// code 0 is ground, then pins, reference clock, pwm units
	assign sources = {capture_pwm_unit_in, ref_clock_in,
		ext_carrier_pin_b, ext_carrier_pin_a, 1'b0}; // [R1] [R2]

	// ========================================
	// the two conditioning paths share one module
	carrier_path #(
		.SEL_W(SEL_W),
		.NSRC(NSRC)
	) u_hi_path (
		.hclk(hclk),
		.hresetn(hresetn),
		.select(hi_sel), // [R1]
		.invert(hi_inv), // [R4]
		.sources(sources),
		.carrier(hi_carrier),
		.fall(hi_fall)
	);

	carrier_path #(
		.SEL_W(SEL_W),
		.NSRC(NSRC)
	) u_lo_path (
		.hclk(hclk),
		.hresetn(hresetn),
		.select(lo_sel), // [R2]
		.invert(lo_inv), // [R5]
		.sources(sources),
		.carrier(lo_carrier),
		.fall(lo_fall)
	);

	// ========================================
	// per source pin suppression
	// a source only loses its pin when a path selects it
	for (genvar i = 0; i < NSRC; i++) begin : g_pin
		assign pin_dis_w[i] =
			(hi_pdis && !hi_sel[SEL_W-1] &&
			hi_sel[IDX_W-1:0] == IDX_W'(i)) || // [R9]
			(lo_pdis && !lo_sel[SEL_W-1] &&
			lo_sel[IDX_W-1:0] == IDX_W'(i)); // [R10]
	end

	// ========================================
	// register read view, bit four of carrier regs is zero
	function automatic logic [7:0] reg_read(
		input modulator_s s,
		input logic [11:0] a
	);
		logic [7:0] v;
		v = 8'h00;
		if (a == `HI_CTRL_OFS) begin
			v = s.hi_ctrl & `CAR_WMASK; // [R11]
		end else if (a == `LO_CTRL_OFS) begin
			v = s.lo_ctrl & `CAR_WMASK; // [R11]
		end else if (a == `MOD_CTRL_OFS) begin
			v = s.mod_ctrl & `MOD_WMASK;
			v[`MOD_STAT_BIT] = s.status;
		end else if (a == `SRC_CTRL_OFS) begin
			v = s.src_ctrl & `SRC_WMASK;
		end
		return v;
	endfunction

	// ========================================
	// next state: bus, path choice, mixer
	always_comb begin
		st_next = st_reg;
		st_next.ready = 1'b1;
		st_next.resp = `HRESP_OKAY;
		// data phase of a write: unmapped addresses are dropped
		if (st_reg.wr_pend) begin
			if (st_reg.wr_addr == `HI_CTRL_OFS) begin
				st_next.hi_ctrl = hwdata[7:0] & `CAR_WMASK; // [R11]
			end else if (st_reg.wr_addr == `LO_CTRL_OFS) begin
				st_next.lo_ctrl = hwdata[7:0] & `CAR_WMASK; // [R11]
			end else if (st_reg.wr_addr == `MOD_CTRL_OFS) begin
				st_next.mod_ctrl = hwdata[7:0] & `MOD_WMASK;
			end else if (st_reg.wr_addr == `SRC_CTRL_OFS) begin
				st_next.src_ctrl = hwdata[7:0] & `SRC_WMASK;
			end
		end
		// address phase; only NONSEQ or SEQ start a transfer
		accept = hsel & hready & htrans[`HTRANS_ACTIVE_BIT];
		st_next.wr_pend = accept & hwrite;
		if (accept) begin
			st_next.wr_addr = haddr[`ADDR_BITS-1:0];
		end
		// path switching, held back by sync until a falling edge
		unique case (st_reg.path)
			PATH_HIGH: begin
				if (!modulator_in && (!hi_sync || hi_fall)) begin
					st_next.path = PATH_LOW; // [R6] [R8]
				end
			end
			PATH_LOW: begin
				if (modulator_in && (!lo_sync || lo_fall)) begin
					st_next.path = PATH_HIGH; // [R7] [R8]
				end
			end
		endcase
		// while disabled the path just tracks the modulator
		if (!mod_en) begin
			st_next.path = modulator_in ? PATH_HIGH : PATH_LOW;
		end
		// mix with the path chosen this edge, so no extra lag
		mixed = (st_next.path == PATH_HIGH) ?
			hi_carrier : lo_carrier; // [R12]
		st_next.status = mod_en & (mixed ^ mod_opol); // [R13]
		st_next.out = st_next.status & mod_oe; // [R14]
		st_next.pin_dis = pin_dis_w; // [R9] [R10]
		// read data from the post-write view so back to back works
		if (accept && !hwrite) begin
			st_next.rdata = {`RDATA_PAD,
				reg_read(st_next, haddr[`ADDR_BITS-1:0])};
		end
	end

	// ========================================
	// state register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_reg.hi_ctrl <= `CAR_RESET;
			st_reg.lo_ctrl <= `CAR_RESET;
			st_reg.mod_ctrl <= `MOD_RESET;
			st_reg.src_ctrl <= `SRC_RESET;
			st_reg.wr_pend <= 1'b0;
			st_reg.wr_addr <= '0;
			st_reg.rdata <= '0;
			st_reg.ready <= 1'b1;
			st_reg.resp <= `HRESP_OKAY;
			st_reg.path <= PATH_LOW;
			st_reg.status <= 1'b0;
			st_reg.out <= 1'b0;
			st_reg.pin_dis <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// ========================================
	// outputs, each straight from the state register
	assign hreadyout = st_reg.ready;
	assign hresp = st_reg.resp;
	assign hrdata = st_reg.rdata;
	assign modulated_output = st_reg.out;
	assign modulated_slew_limit = st_reg.mod_ctrl[`MOD_SLR_BIT];
	assign source_pin_disable = st_reg.pin_dis;

	// ========================================
	// checks
	a_high_select_map: assert property ( // [R1] [R4]
		@(posedge hclk) disable iff (!hresetn)
		!hi_sel[SEL_W-1] |->
		hi_carrier == (sources[hi_sel[IDX_W-1:0]] ^ hi_inv))
		else $error("high carrier not the selected source");

	a_low_select_map: assert property ( // [R2] [R5]
		@(posedge hclk) disable iff (!hresetn)
		!lo_sel[SEL_W-1] |->
		lo_carrier == (sources[lo_sel[IDX_W-1:0]] ^ lo_inv))
		else $error("low carrier not the selected source");

	a_high_sync_hold: assert property ( // [R6]
		@(posedge hclk) disable iff (!hresetn)
		(mod_en && hi_sync && st_reg.path == PATH_HIGH &&
		!modulator_in && !hi_fall) |=> st_reg.path == PATH_HIGH)
		else $error("left high carrier before its falling edge");

	a_low_sync_hold: assert property ( // [R7]
		@(posedge hclk) disable iff (!hresetn)
		(mod_en && lo_sync && st_reg.path == PATH_LOW &&
		modulator_in && !lo_fall) |=> st_reg.path == PATH_LOW)
		else $error("left low carrier before its falling edge");

	a_nosync_switch: assert property ( // [R8]
		@(posedge hclk) disable iff (!hresetn)
		(!hi_sync && !lo_sync) |=>
		st_reg.path == ($past(modulator_in) ? PATH_HIGH : PATH_LOW))
		else $error("unsynchronised path did not follow modulator");

	a_pin_dis_high: assert property ( // [R9]
		@(posedge hclk) disable iff (!hresetn)
		(hi_pdis && !hi_sel[SEL_W-1]) |=>
		source_pin_disable[$past(hi_sel[IDX_W-1:0])])
		else $error("high source pin not suppressed");

	a_pin_dis_low: assert property ( // [R10]
		@(posedge hclk) disable iff (!hresetn)
		(lo_pdis && !lo_sel[SEL_W-1]) |=>
		source_pin_disable[$past(lo_sel[IDX_W-1:0])])
		else $error("low source pin not suppressed");

	a_bit_four_zero: assert property ( // [R11]
		@(posedge hclk) disable iff (!hresetn)
		st_reg.wr_pend |=> !st_reg.hi_ctrl[`CAR_RSVD_BIT] &&
		!st_reg.lo_ctrl[`CAR_RSVD_BIT])
		else $error("unimplemented carrier bit stored");

	a_mix_follows: assert property ( // [R12]
		@(posedge hclk) disable iff (!hresetn)
		(mod_en && mod_oe && !mod_opol && !hi_sync && !lo_sync) |=>
		modulated_output ==
		($past(modulator_in) ? $past(hi_carrier) : $past(lo_carrier)))
		else $error("output not the carrier of the modulator level");

	a_disabled_quiet: assert property ( // [R13]
		@(posedge hclk) disable iff (!hresetn)
		!mod_en |=> !modulated_output && !st_reg.status)
		else $error("output while module disabled");

	a_pin_held_low: assert property ( // [R14]
		@(posedge hclk) disable iff (!hresetn)
		(mod_en && !mod_oe) |=>
		!modulated_output && st_reg.status == $past(mixed ^ mod_opol))
		else $error("pin not low or mixing stopped with output off");

endmodule // modulator_carrier_select

// ### verification/source_model.sv
// carrier source model: two pins, reference clock and four pwm outputs
`timescale 1ns/1ps

// ========================================
// free running waveforms of differing rates
module source_model (
	input wire logic hclk,
	input wire logic hresetn,
	output logic pin_a,
	output logic pin_b,
	output logic ref_clk,
	output logic [3:0] pwm
);
	logic [7:0] cnt_reg;

	// slow sources make the sync paths wait many cycles for a fall
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_reg <= 8'h00;
		end else begin
			cnt_reg <= cnt_reg + 8'h01;
		end
	end

	// all sources change just after an edge, never at it
	assign pin_a = cnt_reg[2] ^ cnt_reg[5];
	assign pin_b = cnt_reg[3];
	assign ref_clk = cnt_reg[0];
	assign pwm[0] = cnt_reg[4];
	assign pwm[1] = cnt_reg[1] & cnt_reg[3];
	assign pwm[2] = cnt_reg[2:0] < 3'h5;
	assign pwm[3] = cnt_reg[4:3] == 2'h0;
endmodule // source_model

// ### verification/modulator_carrier_select_bench.sv
// self-checking bench for the carrier selection block
`timescale 1ns/1ps
`include "modulator_consts.svh"

module modulator_carrier_select_bench;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, modulator_in;
	logic [31:0] haddr, hwdata, hrdata, rd_val;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic pin_a, pin_b, ref_clk, mod_out, slew, hc, lc, hp, lp, pth;
	logic st_e;
	logic [3:0] pwm;
	logic [7:0] pin_dis, hr, lr, mr, v;
	logic [8:0] mix_q[$];
	logic [31:0] rd_q[$];
	int err_total, checks_done;
	event rd_ev;

	modulator_carrier_select dut (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.modulator_in(modulator_in), .ext_carrier_pin_a(pin_a),
		.ext_carrier_pin_b(pin_b), .ref_clock_in(ref_clk),
		.capture_pwm_unit_in(pwm), .modulated_output(mod_out),
		.modulated_slew_limit(slew), .source_pin_disable(pin_dis));
	source_model srcs (.hclk(hclk), .hresetn(hresetn), .pin_a(pin_a),
		.pin_b(pin_b), .ref_clk(ref_clk), .pwm(pwm));

	// ========================================
	// reference model of the mixer
	function automatic logic cond(input logic [7:0] r, input logic [7:0] s);
		cond = (r[3] ? 1'b0 : s[r[2:0]]) ^ r[6];
	endfunction

	function automatic logic [7:0] pdis(input logic [7:0] r);
		pdis = (r[7] && !r[3]) ? 8'h01 << r[2:0] : 8'h00;
	endfunction

	// one note per edge; register writes land at the same edge as in hw
	always @(posedge hclk) begin
		if (hresetn === 1'b1) begin
			v = {pwm, ref_clk, pin_b, pin_a, 1'b0};
			hc = cond(hr, v);
			lc = cond(lr, v);
			if (!mr[7]) begin
				pth = modulator_in;
			end else if (pth && !modulator_in && (!hr[5] || (hp && !hc))) begin
				pth = 1'b0;
			end else if (!pth && modulator_in && (!lr[5] || (lp && !lc))) begin
				pth = 1'b1;
			end
			hp = hc;
			lp = lc;
			// status as registered this edge, read back one edge later
			st_e <= mr[7] & ((pth ? hc : lc) ^ mr[4]);
			mix_q.push_back({mr[7] & mr[6] & ((pth ? hc : lc) ^ mr[4]),
				pdis(hr) | pdis(lr)});
		end
	end

	// ========================================
	// compare tasks and monitors
	task chk_mix(input logic [8:0] e);
		checks_done++;
		// bus status is zero wait and always okay, so it rides along
		if ({hreadyout, hresp, slew, mod_out, pin_dis} !==
			{1'b1, `HRESP_OKAY, mr[5], e}) begin
			err_total++;
			$display("[ERR] %0t mix %h expected %h", $time,
				{hreadyout, hresp, slew, mod_out, pin_dis},
				{1'b1, `HRESP_OKAY, mr[5], e});
		end
	endtask

	task chk_rd(input logic [31:0] e);
		checks_done++;
		if (rd_val !== e) begin
			err_total++;
			$display("[ERR] %0t read %h expected %h", $time, rd_val, e);
		end
	endtask

	always @(negedge hclk) begin
		if (mix_q.size() > 0) chk_mix(mix_q.pop_front());
	end

	initial begin
		forever begin
			@(rd_ev);
			chk_rd(rd_q.pop_front());
		end
	end

	// ========================================
	// bus master tasks
	task wait_rdy;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
	endtask

	task bus_wr(input logic [11:0] a, input logic [7:0] d);
		hsel <= 1'b1;
		haddr <= {20'h00000, a};
		htrans <= 2'h2;
		hwrite <= 1'b1;
		wait_rdy;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h000000, d};
		wait_rdy;
		case (a)
			`HI_CTRL_OFS: hr <= d & `CAR_WMASK;
			`LO_CTRL_OFS: lr <= d & `CAR_WMASK;
			`MOD_CTRL_OFS: mr <= d & `MOD_WMASK;
			default: ;
		endcase
	endtask

	task bus_rd(input logic [11:0] a, input logic [7:0] e);
		logic [7:0] x;
		hsel <= 1'b1;
		haddr <= {20'h00000, a};
		htrans <= 2'h2;
		hwrite <= 1'b0;
		wait_rdy;
		hsel <= 1'b0;
		htrans <= 2'h0;
		wait_rdy;
		rd_val = hrdata;
		// the status bit is the mix latched at the address edge
		x = e;
		if (a == `MOD_CTRL_OFS) x[`MOD_STAT_BIT] = st_e;
		rd_q.push_back({24'h000000, x});
		->rd_ev;
	endtask

	task tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	// ========================================
	// clock, watchdog and test sequence
	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end

	// about 570 cycles expected; seven times that is a hang
	initial begin
		#32000;
		err_total++;
		tally_and_finish;
	end

	initial begin
		{hresetn, hsel, hwrite, modulator_in, hp, lp, pth} = 7'h00;
		{haddr, hwdata, htrans} = 66'h0;
		hsize = 3'h2;
		{hr, lr, mr} = {`CAR_RESET, `CAR_RESET, `MOD_RESET};
		err_total = 0;
		checks_done = 0;
		void'($urandom(67906));
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		bus_rd(`HI_CTRL_OFS, `CAR_RESET);
		bus_rd(`LO_CTRL_OFS, `CAR_RESET);
		bus_rd(`MOD_CTRL_OFS, `MOD_RESET);
		bus_rd(`SRC_CTRL_OFS, `SRC_RESET);
		bus_wr(`HI_CTRL_OFS, 8'hff);
		bus_rd(`HI_CTRL_OFS, 8'hef);
		bus_wr(`LO_CTRL_OFS, 8'h10);
		bus_rd(`LO_CTRL_OFS, 8'h00);
		bus_wr(`SRC_CTRL_OFS, 8'hff);
		bus_rd(`SRC_CTRL_OFS, `SRC_WMASK);
		bus_wr(12'h010, 8'hff);
		bus_rd(12'h010, 8'h00);
		$display("test registers done");
		// every select code on both paths, random invert, sync, disable
		for (int c = 0; c < 16; c++) begin
			bus_wr(`HI_CTRL_OFS, (8'($urandom) & 8'he0) | 8'(c));
			bus_wr(`LO_CTRL_OFS, (8'($urandom) & 8'he0) | 8'(15 - c));
			bus_wr(`MOD_CTRL_OFS, 8'h80 | (8'($urandom) & 8'h71));
			repeat (24) begin
				@(posedge hclk);
				if ($urandom % 4 == 0) modulator_in <= ~modulator_in;
			end
			bus_rd(`MOD_CTRL_OFS, mr);
		end
		bus_rd(`HI_CTRL_OFS, hr);
		bus_rd(`LO_CTRL_OFS, lr);
		$display("test carrier sweep done");
		// disabled module must stay silent even with inverted output
		bus_wr(`MOD_CTRL_OFS, 8'h50);
		repeat (16) begin
			@(posedge hclk);
			modulator_in <= ~modulator_in;
		end
		bus_rd(`MOD_CTRL_OFS, 8'h50);
		$display("test disable done");
		tally_and_finish;
	end
endmodule // modulator_carrier_select_bench
